// >>> logic/adc_seq_top.sv
// conversion sequencer, control words and output bus of the converter
`timescale 1ns/1ps
module adc_seq_top #(
    parameter int NUM_CH = 8
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_cs_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    input  wire logic [1:0] i_addr,
    input  wire logic [7:0] i_data,
    input  wire logic       i_conv_start_strobe_n,
    input  wire logic       i_ext_clk,
    input  wire logic       i_ext_clk_sel,
    input  wire logic       i_flag_mode,
    input  wire logic [9:0] i_core_result,
    output logic      [9:0] o_data,
    output logic            o_data_oe,
    output logic      [2:0] o_mux_ch,
    output logic            o_sampling,
    output logic            o_done_n,
    output logic            o_eoc,
    output logic            o_osc_fast
);
    if (NUM_CH != 1 && NUM_CH != 8) begin : g_chk
        $error("NUM_CH must be 1 or 8");
    end

    //------------------------------------------------------------
    // pin synchronisers
    //------------------------------------------------------------
    localparam int SY_CS   = 0;
    localparam int SY_RD   = 1;
    localparam int SY_WR   = 2;
    localparam int SY_STB  = 3;
    localparam int SY_EXT  = 4;
    localparam int SY_ESEL = 5;
    localparam int SY_FLAG = 6;
    localparam int SY_ADDR = 7;
    localparam int SY_DATA = 9;
    localparam int SY_W    = 17;

    logic [SY_W-1:0] lvl;
    logic [SY_W-1:0] rise;
    logic [SY_W-1:0] fall;
    logic            tick;

    pin_sync #(
        .W    (SY_W),
        .INIT (17'h0000F)
    ) u_sync (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_pin   ({i_data, i_addr, i_flag_mode, i_ext_clk_sel, i_ext_clk,
                   i_conv_start_strobe_n, i_wr_n, i_rd_n, i_cs_n}),
        .o_lvl   (lvl),
        .o_rise  (rise),
        .o_fall  (fall)
    );

    //------------------------------------------------------------
    // host strobes and control words
    //------------------------------------------------------------
    logic [7:0] cw_a_reg;
    logic [7:0] cw_a_next;
    logic [7:0] cw_b_reg;
    logic [7:0] cw_b_next;
    logic       cs_act;
    logic       rd_rise;
    logic       wr_rise;
    logic       selfcfg;
    logic       flag_md;
    logic [1:0] addr;
    logic [7:0] wdata;

    assign cs_act  = ~lvl[SY_CS];
    assign rd_rise = rise[SY_RD] & cs_act;
    assign wr_rise = rise[SY_WR] & cs_act;
    assign selfcfg = rd_rise & ~lvl[SY_WR];
    assign flag_md = lvl[SY_FLAG];
    assign addr    = lvl[SY_ADDR +: 2];
    assign wdata   = lvl[SY_DATA +: 8];

    always_comb begin
        cw_a_next = cw_a_reg;
        cw_b_next = cw_b_reg;
        if (selfcfg) begin
            cw_a_next = adc_seq_pkg::CW_A_RESET;
            cw_b_next = adc_seq_pkg::CW_B_RESET;
        end else if (wr_rise && addr == adc_seq_pkg::ADDR_CW_A) begin
            cw_a_next = wdata;
        end else if (wr_rise && addr == adc_seq_pkg::ADDR_CW_B) begin
            cw_b_next = wdata;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cw_a_reg <= adc_seq_pkg::CW_A_RESET;
            cw_b_reg <= adc_seq_pkg::CW_B_RESET;
        end else begin
            cw_a_reg <= cw_a_next;
            cw_b_reg <= cw_b_next;
        end
    end

    // zero in every field gives strobe start, single channel, slow oscillator
    logic       sweep_on;
    logic       sweep_next;
    logic       sw_mode;
    logic       sw_mode_next;
    logic [2:0] chan_sel;
    logic [2:0] chan_next;
    logic [2:0] last_ch;
    logic [1:0] test_sel;

    // a set reserved bit keeps single mode, so host must write it as zero
    assign sweep_on     = (NUM_CH > 1) & cw_a_reg[adc_seq_pkg::CWA_SWEEP_BIT]
                          & ~cw_b_reg[adc_seq_pkg::CWB_RSVD_BIT];
    assign sweep_next   = (NUM_CH > 1) & cw_a_next[adc_seq_pkg::CWA_SWEEP_BIT]
                          & ~cw_b_next[adc_seq_pkg::CWB_RSVD_BIT];
    assign sw_mode      = cw_a_reg[adc_seq_pkg::CWA_SWSTRT_BIT];
    assign sw_mode_next = cw_a_next[adc_seq_pkg::CWA_SWSTRT_BIT];
    assign chan_sel     = (NUM_CH > 1) ? cw_a_reg[adc_seq_pkg::CWA_CHAN_LSB +: 3] : 3'h0;
    assign chan_next    = (NUM_CH > 1) ? cw_a_next[adc_seq_pkg::CWA_CHAN_LSB +: 3] : 3'h0;
    // sweep set grows two channels per code; codes above 3 sweep all eight
    assign last_ch      = chan_sel[2] ? adc_seq_pkg::LAST_CH_MAX
                                      : {chan_sel[1:0], 1'b1};
    assign test_sel     = cw_b_reg[adc_seq_pkg::CWB_TEST_LSB +: 2];

    //------------------------------------------------------------
    // conversion clock
    //------------------------------------------------------------
    conv_tick_gen u_tick (
        .i_clk      (i_clk),
        .i_rst_n    (i_rst_n),
        .i_ext_sel  (lvl[SY_ESEL]),
        .i_ext_rise (rise[SY_EXT]),
        .i_fast     (cw_b_reg[adc_seq_pkg::CWB_OSC_BIT]),
        .o_tick     (tick)
    );

    //------------------------------------------------------------
    // sample and convert sequencer
    //------------------------------------------------------------
    localparam logic [3:0] SMP_LAST = 4'(adc_seq_pkg::SAMPLE_CYCLES - 1);
    localparam logic [3:0] CNV_LAST = 4'(adc_seq_pkg::CONVERT_CYCLES - 1);

    adc_seq_pkg::seq_state_e state_reg;
    adc_seq_pkg::seq_state_e state_next;
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    logic [2:0] ch_reg;
    logic [2:0] ch_next;
    logic [9:0] res_reg;
    logic [9:0] res_next;
    logic       done_n_next;
    logic       eoc_reg;
    logic       eoc_next;
    logic       done;

    assign done = (state_reg == adc_seq_pkg::ST_CONVERT) && tick && cnt_reg == CNV_LAST
                  && !wr_rise && !selfcfg;

    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        ch_next     = ch_reg;
        res_next    = res_reg;
        done_n_next = 1'b1;
        eoc_next    = eoc_reg;
        if (selfcfg || wr_rise) begin
            // any write ends a running repetition and restarts the sequence
            ch_next    = sweep_next ? 3'h0 : chan_next;
            eoc_next   = 1'b1;
            cnt_next   = 4'h0;
            state_next = adc_seq_pkg::ST_IDLE;
            if (wr_rise && sw_mode_next) begin
                state_next = adc_seq_pkg::ST_SAMPLE;
            end
        end else begin
            case (state_reg)
                adc_seq_pkg::ST_IDLE: begin
                    cnt_next = 4'h0;
                    if (!sw_mode && fall[SY_STB]) begin
                        state_next = adc_seq_pkg::ST_SAMPLE;
                    end else if (sw_mode && rd_rise) begin
                        state_next = adc_seq_pkg::ST_SAMPLE;
                    end
                end
                adc_seq_pkg::ST_SAMPLE: begin
                    if (!sw_mode) begin
                        if (rise[SY_STB]) begin
                            state_next = adc_seq_pkg::ST_CONVERT;
                            cnt_next   = 4'h0;
                            eoc_next   = ~flag_md;
                        end
                    end else if (tick) begin
                        cnt_next = cnt_reg + 4'h1;
                        if (cnt_reg == SMP_LAST) begin
                            state_next = adc_seq_pkg::ST_CONVERT;
                            cnt_next   = 4'h0;
                            eoc_next   = ~flag_md;
                        end
                    end
                end
                adc_seq_pkg::ST_CONVERT: begin
                    if (tick) begin
                        cnt_next = cnt_reg + 4'h1;
                    end
                    if (done) begin
                        state_next  = adc_seq_pkg::ST_IDLE;
                        cnt_next    = 4'h0;
                        res_next    = i_core_result ^ (cw_b_reg[adc_seq_pkg::CWB_FMT_BIT]
                                      ? adc_seq_pkg::TWOS_FLIP : 10'h000);
                        done_n_next = flag_md;
                        eoc_next    = 1'b1;
                        if (!sweep_on) begin
                            ch_next = chan_sel;
                        end else if (ch_reg >= last_ch) begin
                            ch_next = 3'h0;
                        end else begin
                            ch_next = ch_reg + 3'h1;
                        end
                    end
                end
                default: begin
                    state_next = adc_seq_pkg::ST_IDLE;
                    cnt_next   = 4'h0;
                end
            endcase
        end
    end

    //------------------------------------------------------------
    // output bus
    //------------------------------------------------------------
    logic [9:0] data_next;
    logic       oe_next;

    // built from the new result so the bus is valid as the pulse falls
    always_comb begin
        oe_next = cs_act & ~lvl[SY_RD];
        if (cw_b_reg[adc_seq_pkg::CWB_RBACK_BIT]) begin
            // reserved bits return what was stored
            data_next = (test_sel == adc_seq_pkg::TEST_NONE)
                        ? {2'h0, cw_a_reg} : {2'h0, cw_b_reg};
        end else begin
            case (test_sel)
                adc_seq_pkg::TEST_NONE: data_next = res_next;
                adc_seq_pkg::TEST_LOW:  data_next = adc_seq_pkg::TEST_LOW_VAL;
                adc_seq_pkg::TEST_MID:  data_next = adc_seq_pkg::TEST_MID_VAL;
                adc_seq_pkg::TEST_HIGH: data_next = adc_seq_pkg::TEST_HIGH_VAL;
                default:                data_next = res_next;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg  <= adc_seq_pkg::ST_IDLE;
            cnt_reg    <= 4'h0;
            ch_reg     <= 3'h0;
            res_reg    <= 10'h000;
            o_done_n   <= 1'b1;
            eoc_reg    <= 1'b1;
            o_data     <= 10'h000;
            o_data_oe  <= 1'b0;
            o_mux_ch   <= 3'h0;
            o_sampling <= 1'b0;
            o_osc_fast <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            ch_reg     <= ch_next;
            res_reg    <= res_next;
            o_done_n   <= done_n_next;
            eoc_reg    <= eoc_next;
            o_data     <= data_next;
            o_data_oe  <= oe_next;
            o_mux_ch   <= ch_next;
            o_sampling <= (state_next == adc_seq_pkg::ST_SAMPLE);
            o_osc_fast <= cw_b_next[adc_seq_pkg::CWB_OSC_BIT];
        end
    end

    assign o_eoc = eoc_reg;

    //------------------------------------------------------------
    // assertions
    //------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    logic quiet;
    assign quiet = !wr_rise && !selfcfg;

    a_selfcfg_trigger: assert property (
        rise[SY_RD] && cs_act && !lvl[SY_WR] |=> cw_a_reg == 8'h00 && cw_b_reg == 8'h00)
        else $error("dummy read did not self-configure");
    a_selfcfg_zero: assert property (
        selfcfg |=> cw_a_reg == 8'h00 && cw_b_reg == 8'h00 ##1 !o_osc_fast)
        else $error("control words not cleared");
    a_default_mode: assert property (
        cw_a_reg == 8'h00 && cw_b_reg == 8'h00 |-> !sweep_on && !sw_mode)
        else $error("zero words not strobe start single");
    a_strobe_sample: assert property (
        state_reg == adc_seq_pkg::ST_IDLE && !sw_mode && fall[SY_STB] && quiet
        |=> state_reg == adc_seq_pkg::ST_SAMPLE ##0 o_sampling)
        else $error("strobe fall did not start sampling");
    a_strobe_convert: assert property (
        state_reg == adc_seq_pkg::ST_SAMPLE && !sw_mode && rise[SY_STB] && quiet
        |=> state_reg == adc_seq_pkg::ST_CONVERT ##0 !o_sampling)
        else $error("strobe rise did not start conversion");
    a_done_single: assert property (
        !o_done_n |=> o_done_n)
        else $error("completion pulse longer than one cycle");
    a_eoc_flag: assert property (
        $rose(state_reg == adc_seq_pkg::ST_CONVERT) && $past(flag_md) |-> !o_eoc)
        else $error("flag not low at conversion start");
    a_write_start: assert property (
        wr_rise && sw_mode_next |=> state_reg == adc_seq_pkg::ST_SAMPLE)
        else $error("write rise did not start sampling");
    a_sample_len: assert property (
        sw_mode && state_reg == adc_seq_pkg::ST_SAMPLE && tick && cnt_reg == 4'h5 && quiet
        |=> state_reg == adc_seq_pkg::ST_CONVERT && cnt_reg == 4'h0)
        else $error("software sampling not six clocks");
    a_conv_len: assert property (
        state_reg == adc_seq_pkg::ST_CONVERT && tick && cnt_reg == 4'h9 && quiet
        |=> state_reg == adc_seq_pkg::ST_IDLE && o_eoc)
        else $error("conversion not ten clocks");
    a_sweep_step: assert property (
        done && sweep_on |=> o_mux_ch != $past(o_mux_ch))
        else $error("sweep repeated a channel");
    a_sweep_wrap: assert property (
        done && sweep_on && ch_reg == last_ch |=> o_mux_ch == 3'h0)
        else $error("sweep did not wrap to first channel");
    a_test_high: assert property (
        !cw_b_reg[adc_seq_pkg::CWB_RBACK_BIT] && test_sel == 2'h3 |=> o_data == 10'h3FF)
        else $error("self-test 3 value wrong");
    a_result_ready: assert property (
        !o_done_n && test_sel == 2'h0 && !cw_b_reg[adc_seq_pkg::CWB_RBACK_BIT]
        |-> o_data == res_reg)
        else $error("result not on bus with pulse");

    c_selfcfg:   cover property (selfcfg);
    c_hw_done:   cover property (done && !sw_mode);
    c_sw_done:   cover property (done && sw_mode);
    c_sweep_wrp: cover property (done && sweep_on && ch_reg == last_ch);
endmodule : adc_seq_top

// >>> logic/adc_seq_pkg.sv
// constants, field layout and state types of the conversion sequencer
//------------------------------------------------------------
//------------------------------------------------------------
package adc_seq_pkg;
    localparam int         CLK_HZ         = 100_000_000;
    localparam int         OSC_SLOW_HZ    = 10_000_000;
    localparam int         OSC_FAST_HZ    = 20_000_000;
    localparam int         OSC_SLOW_DIV   = CLK_HZ / OSC_SLOW_HZ;
    localparam int         OSC_FAST_DIV   = CLK_HZ / OSC_FAST_HZ;
    localparam int         SAMPLE_CYCLES  = 6;
    localparam int         CONVERT_CYCLES = 10;
    localparam logic [1:0] ADDR_CW_A      = 2'h0;
    localparam logic [1:0] ADDR_CW_B      = 2'h1;
    localparam int         CWA_CHAN_LSB   = 0;
    localparam int         CWA_SWEEP_BIT  = 3;
    localparam int         CWA_SWSTRT_BIT = 7;
    localparam int         CWB_TEST_LSB   = 0;
    localparam int         CWB_RBACK_BIT  = 2;
    localparam int         CWB_FMT_BIT    = 3;
    localparam int         CWB_OSC_BIT    = 6;
    localparam int         CWB_RSVD_BIT   = 7;
    localparam logic [7:0] CW_A_RESET     = 8'h00;
    localparam logic [7:0] CW_B_RESET     = 8'h00;
    localparam logic [1:0] TEST_NONE      = 2'h0;
    localparam logic [1:0] TEST_LOW       = 2'h1;
    localparam logic [1:0] TEST_MID       = 2'h2;
    localparam logic [1:0] TEST_HIGH      = 2'h3;
    localparam logic [9:0] TEST_LOW_VAL   = 10'h000;
    localparam logic [9:0] TEST_MID_VAL   = 10'h200;
    localparam logic [9:0] TEST_HIGH_VAL  = 10'h3FF;
    localparam logic [9:0] TWOS_FLIP      = 10'h200;
    localparam logic [2:0] LAST_CH_MAX    = 3'h7;

    typedef enum logic [2:0] {
        ST_IDLE    = 3'b001,
        ST_SAMPLE  = 3'b010,
        ST_CONVERT = 3'b100
    } seq_state_e;
endpackage : adc_seq_pkg

// >>> logic/pin_sync.sv
// two-flop synchronisers with level and edge outputs for host pins
`timescale 1ns/1ps
module pin_sync #(
    parameter int             W    = 1,
    parameter logic [W-1:0]   INIT = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_pin,
    output logic      [W-1:0] o_lvl,
    output logic      [W-1:0] o_rise,
    output logic      [W-1:0] o_fall
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;

    // edges compare the second and third stage; the first stage feeds only the second
    genvar b;
    for (b = 0; b < W; b++) begin : g_bit
        always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                s1_reg[b] <= INIT[b];
                s2_reg[b] <= INIT[b];
                s3_reg[b] <= INIT[b];
            end else begin
                s1_reg[b] <= i_pin[b];
                s2_reg[b] <= s1_reg[b];
                s3_reg[b] <= s2_reg[b];
            end
        end
        assign o_lvl[b]  = s2_reg[b];
        assign o_rise[b] = s2_reg[b] & ~s3_reg[b];
        assign o_fall[b] = ~s2_reg[b] & s3_reg[b];
    end
endmodule : pin_sync

// >>> logic/conv_tick_gen.sv
// conversion clock tick: internal oscillator divider or external clock edge
`timescale 1ns/1ps
module conv_tick_gen (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_ext_sel,
    input  wire logic i_ext_rise,
    input  wire logic i_fast,
    output logic      o_tick
);
    localparam logic [7:0] SLOW_LIM = 8'(adc_seq_pkg::OSC_SLOW_DIV - 1);
    localparam logic [7:0] FAST_LIM = 8'(adc_seq_pkg::OSC_FAST_DIV - 1);

    logic [7:0] div_reg;
    logic [7:0] div_next;
    logic       tick_reg;
    logic       tick_next;
    logic [7:0] lim;

    always_comb begin
        lim       = i_fast ? FAST_LIM : SLOW_LIM;
        div_next  = div_reg + 8'h01;
        tick_next = 1'b0;
        if (div_reg >= lim) begin
            div_next  = 8'h00;
            tick_next = ~i_ext_sel;
        end
        if (i_ext_sel) begin
            tick_next = i_ext_rise;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_reg  <= 8'h00;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign o_tick = tick_reg;
endmodule : conv_tick_gen

// >>> sim/core_model.sv
// behavioural converter core seen from the sequencer
`timescale 1ns/1ps
module core_model (
    input  wire logic [2:0] i_ch,
    input  wire logic [6:0] i_noise,
    output logic      [9:0] o_result
);
    // channel in the top bits makes a wrong mux show up in the result
    assign o_result = {i_ch, i_noise};
endmodule : core_model

// >>> sim/adc_conversion_sequencer_config_bench.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_config_bench;
    logic       clk, rst_n, cs_n, rd_n, wr_n, cst_n;
    logic [1:0] addr;
    logic [7:0] data;
    logic [6:0] noise;
    logic [9:0] core, dout, v;
    logic [2:0] mux, ch;
    logic       oe, smp, done_n, eoc, fast, flag, esel, eclk;
    int         num_errors, tests_run, cycles, n, seed;
    int         sweep_q[$];
    core_model i_core (.i_ch(mux), .i_noise(noise), .o_result(core));
    adc_seq_top #(.NUM_CH(8)) i_dut (
        .i_clk(clk), .i_rst_n(rst_n), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
        .i_addr(addr), .i_data(data), .i_conv_start_strobe_n(cst_n), .i_ext_clk(eclk),
        .i_ext_clk_sel(esel), .i_flag_mode(flag), .i_core_result(core), .o_data(dout),
        .o_data_oe(oe), .o_mux_ch(mux), .o_sampling(smp), .o_done_n(done_n),
        .o_eoc(eoc), .o_osc_fast(fast));
    task check(input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task step(input int k);
        repeat (k) @(negedge clk);
    endtask : step
    task wr(input logic [1:0] a, input logic [7:0] d);
        cs_n = 0; addr = a; data = d; step(4);
        wr_n = 0; step(4); wr_n = 1; step(4); cs_n = 1; step(3);
    endtask : wr
    task rd();
        cs_n = 0; rd_n = 0; step(5); v = dout;
        check(oe, 1'b1);
        rd_n = 1; step(4); cs_n = 1; step(3);
    endtask : rd
    // done pulse lasts one cycle, so poll every cycle
    task wait_done();
        n = 0;
        while (done_n !== 1'b0 && n < 400) begin step(1); n++; end
        v = dout; ch = mux;
    endtask : wait_done
    task end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    initial begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    // free-running external conversion clock, six bench clocks a period
    initial begin
        eclk = 0;
        forever begin step(3); eclk = ~eclk; end
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin num_errors++; end_sim(); end
    end
    initial begin
        {cs_n, rd_n, wr_n, cst_n} = 4'hF; addr = 0; data = 0; rst_n = 0; noise = 0;
        flag = 0; esel = 0;
        num_errors = 0; tests_run = 0; cycles = 0;
        seed = $urandom(22);
        step(3); rst_n = 1; step(2);
        wr(0, 8'h05); wr(1, 8'h44);
        check(fast, 1'b1);
        rd(); check(v, 10'h005);
        cs_n = 0; wr_n = 0; step(4); rd_n = 0; step(4); rd_n = 1; step(4);
        cs_n = 1; step(2); wr_n = 1; step(2);
        check(fast, 1'b0);
        wr(1, 8'h04); rd(); check(v, 10'h000);
        for (int c = 1; c < 4; c++) begin
            wr(1, 8'(c)); rd();
            check(v, c == 1 ? 10'h000 : c == 2 ? 10'h200 : 10'h3FF);
        end
        wr(0, 8'h05); wr(1, 8'h00); noise = 7'($urandom);
        cst_n = 0; step(6); check(smp, 1'b1);
        cst_n = 1; wait_done();
        check(10'(n >= 94 && n <= 103), 10'h1);
        check(v, {3'h5, noise});
        wr(1, 8'h08); noise = 7'($urandom); data = 8'($urandom % 8);
        wr(0, {5'h10, data[2:0]}); wait_done();
        check(10'(n >= 147 && n <= 156), 10'h1);
        check(v, {data[2:0], noise} ^ 10'h200);
        rd(); wait_done();
        check(10'(n >= 147 && n <= 156), 10'h1);
        check(10'(ch), 10'(data[2:0]));
        // mux moves to the next channel at the done edge, result holds the converted one
        wr(0, 8'h88); sweep_q = {0, 1, 0, 1};
        for (int k = 0; k < 3; k++) begin
            wait_done(); check(v, {3'(sweep_q[k]), noise} ^ 10'h200);
            check(10'(ch), 10'(sweep_q[k + 1]));
            noise = 7'($urandom); rd();
        end
        flag = 1; esel = 1; wr(0, 8'h02); wr(1, 8'h00);
        cst_n = 0; step(6); cst_n = 1; step(4);
        check(eoc, 1'b0);
        n = 0;
        while (eoc !== 1'b1 && n < 400) begin step(1); n++; end
        check(10'(n >= 54 && n <= 59), 10'h1);
        check(dout, {3'h2, noise});
        check(done_n, 1'b1);
        end_sim();
    end
endmodule : adc_conversion_sequencer_config_bench
